// ### lock_fuse_pkg.sv
// Constants for the lock, fuse, signature and trim access block.
package lock_fuse_pkg;
    // Timing: clock period and busy time of one programming operation.
    localparam int CLK_PERIOD_NS = 20;
    localparam int BUSY_TIME_NS  = 1000;
    localparam int BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Synchronised pin vector layout.
    localparam int PIN_W       = 16;
    localparam int PIN_STROBE  = 0;
    localparam int PIN_ACT_LO  = 1;
    localparam int PIN_ACT_HI  = 2;
    localparam int PIN_BS1     = 3;
    localparam int PIN_STORE_N = 4;
    localparam int PIN_OE_N    = 5;
    localparam int PIN_PROG    = 6;
    localparam int PIN_SERIAL  = 7;
    localparam int PIN_DATA    = 8;
    // Action select codes, action_select_hi then action_select_lo.
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;
    // Command bytes.
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
    localparam logic [7:0] CMD_RD_SIG     = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
    // Reset values of fuse and lock bytes; a zero bit is programmed.
    localparam logic [7:0] EXT_FUSE_RST  = 8'hff;
    localparam logic [7:0] EXT_UNUSED    = 8'hf8;
    localparam logic [7:0] HIGH_FUSE_RST = 8'h99;
    localparam logic [7:0] LOW_FUSE_RST  = 8'h62;
    localparam logic [7:0] LOCK_RST      = 8'hff;
    // Field positions.
    localparam int HI_DEBUG_ALLOW = 7;
    localparam int HI_SERIAL_PROG = 5;
    localparam int HI_EEPROM_KEEP = 3;
    localparam int LOCK_MEM_LO    = 0;
    localparam int LOCK_BOOT_LO   = 4;
    localparam int LOCK_BOOT_HI   = 5;
    // Fuse byte select through the low address byte when byte_select_one is high.
    localparam logic [7:0] ADDR_EXT_FUSE = 8'h01;
    // Identification bytes and trim; values are arbitrary.
    localparam logic [7:0] SIG_BYTE0 = 8'h5a;
    localparam logic [7:0] SIG_BYTE1 = 8'h3c;
    localparam logic [7:0] SIG_BYTE2 = 8'h01;
    localparam logic [7:0] RC_TRIM   = 8'h80;
    localparam logic [7:0] BLANK     = 8'hff;
endpackage

// ### lock_fuse_config_access.sv
// Boot lock gating, fuse storage and latching, signature read and trim load.
`timescale 1ns/1ps
// How it works
// - Lock pair 11 leaves boot section open.
// - Pair 10 blocks stores into boot section.
// - Pair 00 blocks stores and application loads.
// - Pair 01 blocks application loads, allows stores.
// - Modes 00/01 suppress interrupts running boot code when vectors are outside boot.
// - Programmed fuse reads 0, unprogrammed reads 1.
// - Extended byte: brownout pair, reset_pin_off, unused ones.
// - High fuse byte layout and its defaults.
// - Serial path cannot change serial_prog_allow.
// - Debugger fuse keeps clocks alive in sleep.
// - eeprom_keep decides whether erase clears EEPROM.
// - Chip erase never changes fuses.
// - Programmed memory_lock_lo freezes all fuses.
// - Fuses captured entering programming mode, applied exiting.
// - eeprom_keep change acts at once.
// - Fuses captured at power-up in normal mode.
// - Three signature bytes always readable.
// - Trim byte copied into trim register at reset.
// - Strobe rising edge performs selected load action.
// - Store or output-enable low runs loaded command.
// - Action codes: address, data, command, idle.
// - Command byte decoding table.
// - ready_busy_n low while an operation runs.
module lock_fuse_config_access (
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Programmer pins.
    input  wire logic       i_crystal_in_strobe,
    input  wire logic       i_action_select_hi,
    input  wire logic       i_action_select_lo,
    input  wire logic       i_byte_select_one,
    input  wire logic       i_store_pulse_n,
    input  wire logic       i_output_enable_n,
    input  wire logic       i_prog_mode,
    input  wire logic       i_serial_path,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    output logic            o_ready_busy_n,
    // CPU instruction side.
    input  wire logic       i_cpu_in_boot,
    input  wire logic       i_store_req,
    input  wire logic       i_store_to_boot,
    input  wire logic       i_load_req,
    input  wire logic       i_load_from_boot,
    input  wire logic       i_vectors_in_boot,
    input  wire logic       i_irq_req,
    output logic            o_store_grant,
    output logic            o_load_grant,
    output logic            o_irq_allow,
    // Fuse values seen by the device.
    output logic      [7:0] o_ext_fuses,
    output logic      [7:0] o_high_fuses,
    output logic      [7:0] o_low_fuses,
    output logic            o_eeprom_keep,
    output logic            o_clock_keep_in_sleep,
    output logic            o_erase_eeprom,
    output logic      [7:0] o_rc_trim
);
    localparam logic [5:0] BUSY_LOAD = 6'(lock_fuse_pkg::BUSY_CYCLES);

    logic [15:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_last_reg;
    logic [7:0]  ext_reg, high_reg, low_reg, lock_reg;
    logic [7:0]  ext_latch_reg, high_latch_reg, low_latch_reg;
    logic [7:0]  cmd_reg, addr_lo_reg, addr_hi_reg, data_lo_reg, data_hi_reg;
    logic [5:0]  busy_reg;
    logic        captured_reg;

    // Three-stage synchroniser; a change is accepted once stages two and three agree.
    always_ff @(posedge i_core_clk) begin
        s1_reg <= {i_data, i_serial_path, i_prog_mode, i_output_enable_n, i_store_pulse_n,
                   i_byte_select_one, i_action_select_hi, i_action_select_lo,
                   i_crystal_in_strobe};
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    wire [15:0] agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pin_reg      <= 16'h0030;
            pin_last_reg <= 16'h0030;
        end else begin
            pin_reg      <= (pin_reg & ~agree) | (s3_reg & agree);
            pin_last_reg <= pin_reg;
        end
    end

    // Pin decoding.
    wire       prog      = pin_reg[lock_fuse_pkg::PIN_PROG];
    wire       bs1       = pin_reg[lock_fuse_pkg::PIN_BS1];
    wire       serial    = pin_reg[lock_fuse_pkg::PIN_SERIAL];
    wire [7:0] din       = pin_reg[lock_fuse_pkg::PIN_DATA +: 8];
    wire [1:0] action    = {pin_reg[lock_fuse_pkg::PIN_ACT_HI], pin_reg[lock_fuse_pkg::PIN_ACT_LO]};
    wire       strobe_up = prog & pin_reg[lock_fuse_pkg::PIN_STROBE]
                         & ~pin_last_reg[lock_fuse_pkg::PIN_STROBE];
    wire       store_dn  = ~pin_reg[lock_fuse_pkg::PIN_STORE_N]
                         & pin_last_reg[lock_fuse_pkg::PIN_STORE_N];
    wire       oe_low    = prog & ~pin_reg[lock_fuse_pkg::PIN_OE_N];
    wire       prog_edge = pin_reg[lock_fuse_pkg::PIN_PROG] ^ pin_last_reg[lock_fuse_pkg::PIN_PROG];
    wire       idle      = (busy_reg == 6'h0);
    wire       exec_go   = prog & store_dn & idle;

    // Command decoding and write permission.
    wire is_erase   = (cmd_reg == lock_fuse_pkg::CMD_CHIP_ERASE);
    wire is_wr_fuse = (cmd_reg == lock_fuse_pkg::CMD_WR_FUSE);
    wire is_wr_lock = (cmd_reg == lock_fuse_pkg::CMD_WR_LOCK);
    wire fuse_open  = lock_reg[lock_fuse_pkg::LOCK_MEM_LO];
    wire fuse_wr    = exec_go & is_wr_fuse & fuse_open;
    wire sel_ext    = bs1 & (addr_lo_reg == lock_fuse_pkg::ADDR_EXT_FUSE);
    wire keep_live  = ~high_reg[lock_fuse_pkg::HI_EEPROM_KEEP];

    // Serial writes keep the current serial_prog_allow value.
    wire [7:0] high_new = serial
        ? {din[7:6], high_reg[lock_fuse_pkg::HI_SERIAL_PROG], din[4:0]} : din;

    // Address, data and command loading on the strobe rising edge.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cmd_reg     <= 8'h00;
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            data_lo_reg <= 8'h00;
            data_hi_reg <= 8'h00;
        end else if (strobe_up) begin
            case (action)
                lock_fuse_pkg::ACT_ADDR: begin
                    if (bs1) addr_hi_reg <= din;
                    else     addr_lo_reg <= din;
                end
                lock_fuse_pkg::ACT_DATA: begin
                    if (bs1) data_hi_reg <= din;
                    else     data_lo_reg <= din;
                end
                lock_fuse_pkg::ACT_CMD: cmd_reg <= din;
                default: ;
            endcase
        end
    end

    // Fuse cells; a chip erase touches only the lock byte.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_reg  <= lock_fuse_pkg::EXT_FUSE_RST;
            high_reg <= lock_fuse_pkg::HIGH_FUSE_RST;
            low_reg  <= lock_fuse_pkg::LOW_FUSE_RST;
        end else if (fuse_wr) begin
            if (sel_ext)  ext_reg  <= din | lock_fuse_pkg::EXT_UNUSED;
            else if (bs1) high_reg <= high_new;
            else          low_reg  <= din;
        end
    end

    // Lock byte: bits only program, and erase returns them to ones.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lock_reg <= lock_fuse_pkg::LOCK_RST;
        end else if (exec_go & is_erase) begin
            lock_reg <= lock_fuse_pkg::LOCK_RST;
        end else if (exec_go & is_wr_lock) begin
            lock_reg <= lock_reg & din;
        end
    end

    // Busy counter for every executed operation.
    always_ff @(posedge i_core_clk) begin
        if (i_rst)        busy_reg <= 6'h0;
        else if (exec_go) busy_reg <= BUSY_LOAD;
        else if (!idle)   busy_reg <= busy_reg - 6'h1;
    end

    // Fuse latching after power-up and on each programming mode change.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            captured_reg   <= 1'b0;
            ext_latch_reg  <= lock_fuse_pkg::EXT_FUSE_RST;
            high_latch_reg <= lock_fuse_pkg::HIGH_FUSE_RST;
            low_latch_reg  <= lock_fuse_pkg::LOW_FUSE_RST;
        end else if (!captured_reg || prog_edge) begin
            captured_reg   <= 1'b1;
            ext_latch_reg  <= ext_reg;
            high_latch_reg <= high_reg;
            low_latch_reg  <= low_reg;
        end
    end

    // Read data selection for the output-enable phase.
    wire [7:0] sig_byte = (addr_lo_reg == 8'h00) ? (bs1 ? lock_fuse_pkg::RC_TRIM
                                                        : lock_fuse_pkg::SIG_BYTE0)
                        : (addr_lo_reg == 8'h01) ? lock_fuse_pkg::SIG_BYTE1
                        : (addr_lo_reg == 8'h02) ? lock_fuse_pkg::SIG_BYTE2
                        : lock_fuse_pkg::BLANK;
    wire [7:0] fuse_byte = sel_ext ? ext_reg : (bs1 ? high_reg : low_reg);
    wire [7:0] rd_byte   = (cmd_reg == lock_fuse_pkg::CMD_RD_SIG)  ? sig_byte
                         : (cmd_reg == lock_fuse_pkg::CMD_RD_FUSE) ? (addr_lo_reg[1]
                                                                      ? lock_reg : fuse_byte)
                         : lock_fuse_pkg::BLANK;

    // Programmer-facing outputs.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_data         <= 8'h00;
            o_data_oe      <= 1'b0;
            o_ready_busy_n <= 1'b1;
            o_erase_eeprom <= 1'b0;
        end else begin
            o_data         <= oe_low ? rd_byte : 8'h00;
            o_data_oe      <= oe_low;
            o_ready_busy_n <= idle & ~exec_go;
            o_erase_eeprom <= exec_go & is_erase & ~keep_live;
        end
    end

    // Boot lock decoding for the CPU side.
    wire boot_lo    = lock_reg[lock_fuse_pkg::LOCK_BOOT_LO];
    wire boot_hi    = lock_reg[lock_fuse_pkg::LOCK_BOOT_HI];
    wire store_ok   = ~i_store_to_boot | boot_lo;
    wire load_ok    = ~i_load_from_boot | i_cpu_in_boot | boot_hi;
    wire irq_masked = ~boot_hi & ~i_vectors_in_boot & i_cpu_in_boot;

    // CPU-facing outputs, trim register and latched fuse views.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_store_grant         <= 1'b0;
            o_load_grant          <= 1'b0;
            o_irq_allow           <= 1'b0;
            o_rc_trim             <= lock_fuse_pkg::RC_TRIM;
            o_ext_fuses           <= lock_fuse_pkg::EXT_FUSE_RST;
            o_high_fuses          <= lock_fuse_pkg::HIGH_FUSE_RST;
            o_low_fuses           <= lock_fuse_pkg::LOW_FUSE_RST;
            o_eeprom_keep         <= 1'b0;
            o_clock_keep_in_sleep <= 1'b0;
        end else begin
            o_store_grant         <= i_store_req & store_ok;
            o_load_grant          <= i_load_req & load_ok;
            o_irq_allow           <= i_irq_req & ~irq_masked;
            o_ext_fuses           <= ext_latch_reg;
            o_high_fuses          <= high_latch_reg;
            o_low_fuses           <= low_latch_reg;
            o_eeprom_keep         <= keep_live;
            o_clock_keep_in_sleep <= ~high_latch_reg[lock_fuse_pkg::HI_DEBUG_ALLOW];
        end
    end

    // Checks on the gating, fuse protection, busy and reset behaviour.
    a_store_blocked: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_store_req && i_store_to_boot && !boot_lo) |=> !o_store_grant)
        else $error("store into locked boot section granted");
    a_store_open: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_store_req && boot_lo) |=> o_store_grant)
        else $error("store refused with boot store lock open");
    a_load_blocked: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_load_req && i_load_from_boot && !i_cpu_in_boot && !boot_hi) |=> !o_load_grant)
        else $error("application load from locked boot section granted");
    a_load_open: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_load_req && boot_hi) |=> o_load_grant)
        else $error("load refused with boot load lock open");
    a_irq_suppress: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_irq_req && !boot_hi && !i_vectors_in_boot && i_cpu_in_boot) |=> !o_irq_allow)
        else $error("interrupt passed while boot code runs locked");
    a_fuse_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !lock_reg[lock_fuse_pkg::LOCK_MEM_LO] |=> $stable({ext_reg, high_reg, low_reg}))
        else $error("fuse changed while memory lock set");
    a_erase_fuses: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (exec_go && is_erase) |=> ($stable({ext_reg, high_reg, low_reg})
                                   && lock_reg == lock_fuse_pkg::LOCK_RST))
        else $error("chip erase altered fuses or kept locks");
    a_busy_span: assert property (@(posedge i_core_clk) disable iff (i_rst)
        exec_go |=> !o_ready_busy_n [*8] ##[40:60] o_ready_busy_n)
        else $error("ready_busy_n timing wrong");
    a_ext_unused: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ext_reg[7:3] == 5'h1f)
        else $error("unused extended fuse bits not one");
    a_trim_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(i_rst) |-> o_rc_trim == lock_fuse_pkg::RC_TRIM)
        else $error("trim not loaded at reset");
    a_keep_live: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(high_reg[lock_fuse_pkg::HI_EEPROM_KEEP]) |=> o_eeprom_keep == keep_live)
        else $error("eeprom_keep not applied at once");
endmodule // lock_fuse_config_access

// ### prog_pins.sv
// Parallel programmer model that drives the device's programming pins.
`timescale 1ns/1ps
module prog_pins (
    // Clock and read answer.
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rdata_oe,
    // Programming pins.
    output logic            o_strobe,
    output logic      [1:0] o_act,
    output logic            o_bs1,
    output logic            o_store_n,
    output logic            o_oe_n,
    output logic      [7:0] o_data
);
    // Pins start idle; action code 11 does nothing.
    initial begin
        o_strobe = 1'b0;
        o_act = 2'h3;
        o_bs1 = 1'b0;
        o_store_n = 1'b1;
        o_oe_n = 1'b1;
        o_data = 8'ha5;
    end
    // Waits a number of clock edges.
    task automatic hold(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // Sets action, byte select and data well before the strobe rises.
    task automatic load(input logic [1:0] a, input logic bs, input logic [7:0] d);
        o_act <= a;
        o_bs1 <= bs;
        o_data <= d;
        hold(6);
        o_strobe <= 1'b1;
        hold(6);
        o_strobe <= 1'b0;
        hold(6);
        o_act <= 2'h3;
        o_data <= ~d;
        hold(2);
    endtask
    // Pulses the store line low with byte select and data held.
    task automatic exec(input logic bs, input logic [7:0] d);
        o_bs1 <= bs;
        o_data <= d;
        hold(6);
        o_store_n <= 1'b0;
        hold(6);
        o_store_n <= 1'b1;
        o_data <= ~d;
        hold(2);
    endtask
    // Holds output enable low until the read data has settled.
    task automatic read(input logic bs, output logic [7:0] d, output logic oe);
        o_bs1 <= bs;
        o_oe_n <= 1'b0;
        hold(8);
        d = i_rdata;
        oe = i_rdata_oe;
        o_oe_n <= 1'b1;
        hold(6);
    endtask
endmodule // prog_pins

// ### lock_fuse_config_access_test.sv
// Self-checking testbench for the lock, fuse, signature and trim block.
`timescale 1ns/1ps
module lock_fuse_config_access_test;
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        prog = 1'b0;
    logic        serial = 1'b0;
    logic  [6:0] cpu = 7'h0;
    logic        strobe, bs1, store_n, oe_n, oe, rdy, sg, lg, ia, keep, ckeep, ers;
    logic  [1:0] act;
    logic  [7:0] pdata, rdata, ext_f, high_f, low_f, trim, v, lowv, extv, lock;
    logic [31:0] seed = 32'h49;
    int          miscompares = 0;
    int          checks = 0;
    int          erases = 0;
    // Clock of 20 ns period, and a count of EEPROM-clearing erase pulses.
    always #10 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (ers === 1'b1) erases <= erases + 1;
    // Block under test.
    lock_fuse_config_access dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_crystal_in_strobe(strobe),
        .i_action_select_hi(act[1]), .i_action_select_lo(act[0]), .i_byte_select_one(bs1),
        .i_store_pulse_n(store_n), .i_output_enable_n(oe_n), .i_prog_mode(prog),
        .i_serial_path(serial), .i_data(pdata), .o_data(rdata), .o_data_oe(oe),
        .o_ready_busy_n(rdy), .i_cpu_in_boot(cpu[0]), .i_store_req(cpu[1]),
        .i_store_to_boot(cpu[2]), .i_load_req(cpu[3]), .i_load_from_boot(cpu[4]),
        .i_vectors_in_boot(cpu[5]), .i_irq_req(cpu[6]), .o_store_grant(sg),
        .o_load_grant(lg), .o_irq_allow(ia), .o_ext_fuses(ext_f), .o_high_fuses(high_f),
        .o_low_fuses(low_f), .o_eeprom_keep(keep), .o_clock_keep_in_sleep(ckeep),
        .o_erase_eeprom(ers), .o_rc_trim(trim));
    // Programmer on the far side of the pins.
    prog_pins pgm (
        .i_core_clk(i_core_clk), .i_rdata(rdata), .i_rdata_oe(oe), .o_strobe(strobe),
        .o_act(act), .o_bs1(bs1), .o_store_n(store_n), .o_oe_n(oe_n), .o_data(pdata));
    // Xorshift generator with a fixed start.
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // Expected {irq_allow, load_grant, store_grant} for a lock byte and requests.
    function automatic logic [7:0] grants(input logic [7:0] lk, input logic [7:0] r);
        return {5'h0, r[6] & ~(r[0] & ~r[5] & ~lk[5]), r[3] & ~(r[4] & ~r[0] & ~lk[5]),
                r[1] & ~(r[2] & ~lk[4])};
    endfunction
    // Compares one value and reports a mismatch at once.
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Loads command, address and data, runs it and waits for ready under a bound.
    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic bs,
                      input logic [7:0] d);
        int n;
        pgm.load(2'h2, 1'b0, c);
        pgm.load(2'h0, 1'b0, a);
        pgm.load(2'h1, 1'b0, d);
        pgm.exec(bs, d);
        cmp8("ready_busy_n", 8'h0, {7'h0, rdy});
        for (n = 0; n < 60 && rdy !== 1'b1; n++) pgm.hold(1);
        if (n == 60) begin
            miscompares++;
            finish_test();
        end
    endtask
    // Loads a read command and address, reads through output enable and compares.
    task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic bs,
                      input logic [7:0] e);
        logic o;
        pgm.load(2'h2, 1'b0, c);
        pgm.load(2'h0, 1'b0, a);
        pgm.read(bs, v, o);
        cmp8("data_oe", 8'h1, {7'h0, o});
        cmp8("read data", e, v);
    endtask
    // Changes programming mode and lets the level pass the pin filter.
    task automatic mode(input logic p);
        prog <= p;
        pgm.hold(10);
    endtask
    // Random instruction-side requests against the current lock byte.
    task automatic cpu_round();
        logic [7:0] r;
        repeat (24) begin
            r = rnd();
            cpu <= r[6:0];
            @(posedge i_core_clk);
            #1;
            cmp8("cpu grants", grants(lock, r), {5'h0, ia, lg, sg});
            @(posedge i_core_clk);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        cmp8("ext fuses", 8'hff, ext_f);
        cmp8("high fuses", 8'h99, high_f);
        cmp8("low fuses", 8'h62, low_f);
        cmp8("trim", lock_fuse_pkg::RC_TRIM, trim);
        cmp8("status", 8'h4, {5'h0, rdy, keep, ckeep});
        @(posedge i_core_clk);
        lock = 8'hff;
        cpu_round();
        $display("test defaults done");
        mode(1'b1);
        rd(8'h08, 8'h00, 1'b0, lock_fuse_pkg::SIG_BYTE0);
        rd(8'h08, 8'h01, 1'b0, lock_fuse_pkg::SIG_BYTE1);
        rd(8'h08, 8'h02, 1'b0, lock_fuse_pkg::SIG_BYTE2);
        rd(8'h08, 8'h00, 1'b1, lock_fuse_pkg::RC_TRIM);
        rd(8'h04, 8'h01, 1'b1, 8'hff);
        rd(8'h04, 8'h02, 1'b0, 8'hff);
        wr(8'h10, 8'h00, 1'b0, 8'h00);
        wr(8'h11, 8'h00, 1'b0, 8'h00);
        rd(8'h02, 8'h00, 1'b0, lock_fuse_pkg::BLANK);
        rd(8'h03, 8'h00, 1'b0, lock_fuse_pkg::BLANK);
        $display("test signature done");
        lowv = rnd();
        wr(8'h40, 8'h00, 1'b0, lowv);
        rd(8'h04, 8'h00, 1'b0, lowv);
        wr(8'h40, 8'h00, 1'b1, 8'h91);
        cmp8("eeprom_keep", 8'h1, {7'h0, keep});
        cmp8("latched high", 8'h99, high_f);
        cmp8("latched low", 8'h62, low_f);
        extv = rnd();
        wr(8'h40, 8'h01, 1'b1, extv);
        extv = extv | 8'hf8;
        rd(8'h04, 8'h01, 1'b1, extv);
        serial <= 1'b1;
        wr(8'h40, 8'h00, 1'b1, 8'hb1);
        rd(8'h04, 8'h00, 1'b1, 8'h91);
        serial <= 1'b0;
        wr(8'h80, 8'h00, 1'b0, 8'h00);
        rd(8'h04, 8'h00, 1'b0, lowv);
        cmp8("erase pulses", 8'h0, erases[7:0]);
        mode(1'b0);
        cmp8("low after exit", lowv, low_f);
        cmp8("high after exit", 8'h91, high_f);
        cmp8("ext after exit", extv, ext_f);
        $display("test fuses done");
        mode(1'b1);
        wr(8'h20, 8'h00, 1'b0, 8'hef);
        lock = 8'hef;
        rd(8'h04, 8'h02, 1'b0, lock);
        mode(1'b0);
        cpu_round();
        mode(1'b1);
        wr(8'h20, 8'h00, 1'b0, 8'hdf);
        lock = 8'hcf;
        mode(1'b0);
        cpu_round();
        mode(1'b1);
        wr(8'h40, 8'h00, 1'b1, 8'h19);
        wr(8'h80, 8'h00, 1'b0, 8'h00);
        cmp8("erase pulses", 8'h1, erases[7:0]);
        wr(8'h20, 8'h00, 1'b0, 8'hdf);
        lock = 8'hdf;
        mode(1'b0);
        cmp8("clock keep", 8'h1, {7'h0, ckeep});
        cpu_round();
        $display("test locks done");
        mode(1'b1);
        wr(8'h20, 8'h00, 1'b0, 8'hde);
        wr(8'h40, 8'h00, 1'b0, ~lowv);
        rd(8'h04, 8'h00, 1'b0, lowv);
        rd(8'h08, 8'h01, 1'b0, lock_fuse_pkg::SIG_BYTE1);
        $display("test memory lock done");
        finish_test();
    end
endmodule // lock_fuse_config_access_test
